// File: hw/tpo_pkg.sv
// Shared constants of the timing pattern output block: register indices,
// field positions, reset values and bus-side state encodings.
// Assumes a 32-bit AHB-Lite slave port; byte address = 4 * register index.
package tpo_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [19:0] IDX_PORTA_DIR = 20'hEE009;
    localparam logic [19:0] IDX_PORTB_DIR = 20'hEE00A;
    localparam logic [19:0] IDX_MODE = 20'hFFFA0;
    localparam logic [19:0] IDX_TRIG_SEL = 20'hFFFA1;
    localparam logic [19:0] IDX_HI_EN = 20'hFFFA2;
    localparam logic [19:0] IDX_LO_EN = 20'hFFFA3;
    localparam logic [19:0] IDX_HI_STAGED = 20'hFFFA4;
    localparam logic [19:0] IDX_LO_STAGED = 20'hFFFA5;
    localparam logic [19:0] IDX_HI_ALT = 20'hFFFA6;
    localparam logic [19:0] IDX_LO_ALT = 20'hFFFA7;
    localparam logic [19:0] IDX_PORTA_DATA = 20'hFFFD9;
    localparam logic [19:0] IDX_PORTB_DATA = 20'hFFFDA;

    // Reset values
    localparam logic [7:0] RST_MODE = 8'hF0;
    localparam logic [7:0] RST_TRIG_SEL = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [3:0] RST_NIBBLE = 4'h0;

    // Reserved nibbles and bytes read as all ones
    localparam logic [3:0] RSV_NIBBLE = 4'hF;
    localparam logic [7:0] RSV_BYTE = 8'hFF;

    // Field layout: two trigger select bits per group, group n at bit 2n
    localparam int TRIG_FIELD_W = 2;
    localparam logic [1:0] SEL_CH0 = 2'h0;
    localparam logic [1:0] SEL_CH1 = 2'h1;
    localparam int NUM_GROUPS = 4;
    localparam int NUM_CHANNELS = 3;

    // AHB-Lite transfer type bit that marks NONSEQ or SEQ
    localparam int HTRANS_ACTIVE_BIT = 1;

    // Bus-side states, Gray coded along idle -> wait -> data
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_RWAIT = 2'h1,
        BUS_RDATA = 2'h3,
        BUS_WRITE = 2'h2
    } tpo_bus_t;

endpackage

// File: hw/tpo_group.sv
// One 4-bit pattern output group: owns its slice of the port output latch.
// Assumes trigger pulses are already registered and last one cycle.
`timescale 1ns/1ns
module tpo_group
    import tpo_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_trig_a,
    input wire logic i_trig_b,
    input wire logic i_nov,
    input wire logic [3:0] i_en,
    input wire logic [3:0] i_staged,
    input wire logic i_wr,
    input wire logic [3:0] i_wdata,
    output logic [3:0] o_q
);

    logic [3:0] nxt_q;

    // Software writes land only on bits not given to pattern output;
    // the trigger then moves staged bits onto the enabled ones
    always_comb begin
        nxt_q = o_q;
        if (i_wr) begin
            nxt_q = (o_q & i_en) | (i_wdata & ~i_en);
        end
        if (i_trig_a) begin
            if (i_nov) begin
                // Falling bits go now, rising bits wait for the margin event
                nxt_q = nxt_q & ~(i_en & ~i_staged);
            end else begin
                nxt_q = (nxt_q & ~i_en) | (i_staged & i_en);
            end
        end
        if (i_trig_b && i_nov) begin
            nxt_q = nxt_q | (i_en & i_staged);
        end
    end

    // Output latch
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_q <= RST_NIBBLE;
        end else begin
            o_q <= nxt_q;
        end
    end

endmodule // tpo_group

// File: hw/tpo_top.sv
// Timing pattern output block: AHB-Lite register file, trigger selection,
// staged data, DMA requests and four 4-bit output groups.
// Assumes compare-match inputs are one-cycle pulses synchronous to the clock.
`timescale 1ns/1ns
module tpo_top
    import tpo_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic [2:0] i_cmp_a,
    input wire logic [2:0] i_cmp_b,
    output logic [15:0] o_pattern_pin,
    output logic [15:0] o_pattern_dir,
    output logic [2:0] o_dma_req
);

    tpo_bus_t bus_state_ff;
    logic [19:0] addr_ff;
    logic [3:0] mode_ff;
    logic [7:0] trig_sel_ff;
    logic [7:0] lo_en_ff;
    logic [7:0] hi_en_ff;
    logic [7:0] lo_staged_ff;
    logic [7:0] hi_staged_ff;
    logic [7:0] porta_dir_ff;
    logic [7:0] portb_dir_ff;
    logic [2:0] cmp_a_ff;
    logic [2:0] cmp_b_ff;
    logic [3:0] trig_a_grp;
    logic [3:0] trig_b_grp;
    logic [15:0] grp_en;
    logic [15:0] grp_staged;
    logic [2:0] dma_mask;
    logic same_lo;
    logic same_hi;
    logic accept;
    logic wr_now;
    logic [7:0] wdata;
    logic [7:0] rd_mux;

    // Picks the compare-match pulse of the channel a group selects;
    // both upper codes mean the third channel
    function automatic logic tpo_chan(input logic [1:0] sel, input logic [2:0] vec);
        return (sel == SEL_CH0) ? vec[0] : ((sel == SEL_CH1) ? vec[1] : vec[2]);
    endfunction

    // Bus handshake terms; writes complete in their data phase
    assign accept = i_hsel && i_htrans[HTRANS_ACTIVE_BIT] && i_hready;
    assign wr_now = (bus_state_ff == BUS_WRITE);
    assign wdata = i_hwdata[7:0];

    // pairing by channel; codes 2 and 3 both pick the third channel
    assign same_lo = (trig_sel_ff[1:0] == trig_sel_ff[3:2]) || (trig_sel_ff[1] && trig_sel_ff[3]);
    // pairing by channel, same folding of the upper codes
    assign same_hi = (trig_sel_ff[5:4] == trig_sel_ff[7:6]) || (trig_sel_ff[5] && trig_sel_ff[7]);

    assign grp_en = {hi_en_ff, lo_en_ff};
    assign grp_staged = {hi_staged_ff, lo_staged_ff};

    always_comb begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
            trig_a_grp[g] = tpo_chan(trig_sel_ff[g*TRIG_FIELD_W +: TRIG_FIELD_W], cmp_a_ff);
            trig_b_grp[g] = tpo_chan(trig_sel_ff[g*TRIG_FIELD_W +: TRIG_FIELD_W], cmp_b_ff);
        end
    end

    // Channels that some group with at least one enabled bit listens to
    always_comb begin
        dma_mask = '0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            for (int c = 0; c < NUM_CHANNELS; c++) begin
                if (|grp_en[g*4 +: 4] && tpo_chan(trig_sel_ff[g*2 +: 2], 3'(1 << c))) begin
                    dma_mask[c] = 1'b1;
                end
            end
        end
    end

    // Bus state: reads take one wait state so the read mux sees any
    // write that finished in the same edge as the read address phase
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            bus_state_ff <= BUS_IDLE;
        end else if (bus_state_ff == BUS_RWAIT) begin
            bus_state_ff <= BUS_RDATA;
        end else if (accept) begin
            bus_state_ff <= i_hwrite ? BUS_WRITE : BUS_RWAIT;
        end else begin
            bus_state_ff <= BUS_IDLE;
        end
    end

    // Address capture; upper address bits are not decoded
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            addr_ff <= '0;
        end else if (accept) begin
            addr_ff <= i_haddr[21:2];
        end
    end

    // Ready and response; the response is always OKAY
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= !(accept && !i_hwrite);
            o_hresp <= 1'b0;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        case (addr_ff)
            IDX_MODE: rd_mux = {RSV_NIBBLE, mode_ff};
            IDX_TRIG_SEL: rd_mux = trig_sel_ff;
            IDX_HI_EN: rd_mux = hi_en_ff;
            IDX_LO_EN: rd_mux = lo_en_ff;
            IDX_HI_STAGED: rd_mux = same_hi ? hi_staged_ff : {hi_staged_ff[7:4], RSV_NIBBLE};
            IDX_LO_STAGED: rd_mux = same_lo ? lo_staged_ff : {lo_staged_ff[7:4], RSV_NIBBLE};
            IDX_HI_ALT: rd_mux = same_hi ? RSV_BYTE : {RSV_NIBBLE, hi_staged_ff[3:0]};
            IDX_LO_ALT: rd_mux = same_lo ? RSV_BYTE : {RSV_NIBBLE, lo_staged_ff[3:0]};
            IDX_PORTA_DATA: rd_mux = o_pattern_pin[7:0];
            IDX_PORTB_DATA: rd_mux = o_pattern_pin[15:8];
            default: rd_mux = RST_ZERO;
        endcase
    end

    // Read data register
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_hrdata <= '0;
        end else if (bus_state_ff == BUS_RWAIT) begin
            o_hrdata <= {24'h000000, rd_mux};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            mode_ff <= RST_MODE[3:0];
            trig_sel_ff <= RST_TRIG_SEL;
            lo_en_ff <= RST_ZERO;
            hi_en_ff <= RST_ZERO;
        end else if (wr_now) begin
            if (addr_ff == IDX_MODE) begin
                mode_ff <= wdata[3:0];
            end
            if (addr_ff == IDX_TRIG_SEL) begin
                trig_sel_ff <= wdata;
            end
            if (addr_ff == IDX_HI_EN) begin
                hi_en_ff <= wdata;
            end
            if (addr_ff == IDX_LO_EN) begin
                lo_en_ff <= wdata;
            end
        end
    end

    // staged data with address that follows trigger pairing
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            lo_staged_ff <= RST_ZERO;
            hi_staged_ff <= RST_ZERO;
        end else if (wr_now) begin
            if (addr_ff == IDX_LO_STAGED) begin
                lo_staged_ff[7:4] <= wdata[7:4];
                if (same_lo) begin
                    lo_staged_ff[3:0] <= wdata[3:0];
                end
            end
            if (addr_ff == IDX_LO_ALT && !same_lo) begin
                lo_staged_ff[3:0] <= wdata[3:0];
            end
            if (addr_ff == IDX_HI_STAGED) begin
                hi_staged_ff[7:4] <= wdata[7:4];
                if (same_hi) begin
                    hi_staged_ff[3:0] <= wdata[3:0];
                end
            end
            if (addr_ff == IDX_HI_ALT && !same_hi) begin
                hi_staged_ff[3:0] <= wdata[3:0];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            porta_dir_ff <= RST_ZERO;
            portb_dir_ff <= RST_ZERO;
        end else if (wr_now) begin
            if (addr_ff == IDX_PORTA_DIR) begin
                porta_dir_ff <= wdata;
            end
            if (addr_ff == IDX_PORTB_DIR) begin
                portb_dir_ff <= wdata;
            end
        end
    end

    // direction is software's job; pins simply show it
    assign o_pattern_dir = {portb_dir_ff, porta_dir_ff};

    // triggers are registered, latches move one cycle later
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cmp_a_ff <= '0;
            cmp_b_ff <= '0;
        end else begin
            cmp_a_ff <= i_cmp_a;
            cmp_b_ff <= i_cmp_b;
        end
    end

    // DMA request, aligned with the latch update it refills after
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_dma_req <= '0;
        end else begin
            o_dma_req <= cmp_a_ff & dma_mask;
        end
    end

    // four independent groups, copy on trigger, margin
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : gen_grp
        tpo_group u_grp (
            .i_core_clk(i_core_clk),
            .i_sys_rst(i_sys_rst),
            .i_trig_a(trig_a_grp[g]),
            .i_trig_b(trig_b_grp[g]),
            .i_nov(mode_ff[g]),
            .i_en(grp_en[g*4 +: 4]),
            .i_staged(grp_staged[g*4 +: 4]),
            // port writes gated by enables inside
            .i_wr(wr_now && addr_ff == ((g < 2) ? IDX_PORTA_DATA : IDX_PORTB_DATA)),
            .i_wdata(wdata[(g % 2)*4 +: 4]),
            .o_q(o_pattern_pin[g*4 +: 4])
        );
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    // enabled bits of group 0 take staged data
    AST_COPY_G0: assert property (
        trig_a_grp[0] && !mode_ff[0] |=>
            (o_pattern_pin[3:0] & $past(lo_en_ff[3:0]))
                == ($past(lo_staged_ff[3:0]) & $past(lo_en_ff[3:0])))
        else $error("group 0 did not copy staged data");
    // latch moves two cycles after the compare pulse
    AST_LATENCY_G3: assert property (
        i_cmp_a[0] && trig_sel_ff[7:6] == SEL_CH0 && hi_en_ff[7:4] == 4'hF
            && !mode_ff[3] && !i_cmp_b[0] && !wr_now ##1 !wr_now && $stable(trig_sel_ff)
            && $stable(hi_en_ff) |=> o_pattern_pin[15:12] == $past(hi_staged_ff[7:4], 1))
        else $error("group 3 latch not updated in time");
    AST_PROTECT: assert property (
        wr_now && addr_ff == IDX_PORTA_DATA && !trig_a_grp[0] && !trig_a_grp[1]
            && !trig_b_grp[0] && !trig_b_grp[1] |=>
            ((o_pattern_pin[7:0] ^ $past(o_pattern_pin[7:0])) & $past(lo_en_ff)) == 8'h00)
        else $error("write changed a pattern-owned port bit");
    // rising bits held back in non-overlap mode
    AST_NOV_HOLD: assert property (
        trig_a_grp[1] && mode_ff[1] && !trig_b_grp[1] |=>
            ((o_pattern_pin[7:4] & ~$past(o_pattern_pin[7:4])) & $past(lo_en_ff[7:4])) == 4'h0)
        else $error("non-overlap group rose before margin");
    // a selected compare A trigger always gives a DMA request
    AST_DMA: assert property (
        (|(cmp_a_ff & dma_mask)) |=> (|o_dma_req))
        else $error("selected trigger gave no DMA request");
    AST_RST_VALUES: assert property (
        $past(i_sys_rst) |-> {RSV_NIBBLE, mode_ff} == RST_MODE && trig_sel_ff == RST_TRIG_SEL
            && lo_staged_ff == RST_ZERO && hi_en_ff == RST_ZERO)
        else $error("control registers wrong after reset");
    AST_DIR_RST: assert property (
        $past(i_sys_rst) |-> o_pattern_dir == 16'h0000 && o_pattern_pin == 16'h0000)
        else $error("port registers wrong after reset");
    // split address keeps group 0 half
    AST_LO_SPLIT: assert property (
        wr_now && addr_ff == IDX_LO_STAGED && !same_lo |=>
            lo_staged_ff[3:0] == $past(lo_staged_ff[3:0]))
        else $error("low staged nibble written at shared address");
    // split address keeps group 2 half
    AST_HI_SPLIT: assert property (
        wr_now && addr_ff == IDX_HI_STAGED && !same_hi |=>
            hi_staged_ff[3:0] == $past(hi_staged_ff[3:0]))
        else $error("high staged nibble written at shared address");
    AST_RSV_READ: assert property (
        bus_state_ff == BUS_RWAIT && addr_ff == IDX_LO_ALT && same_lo
            |=> o_hrdata == 32'h000000FF && o_hreadyout)
        else $error("reserved staged address read wrong");

endmodule // tpo_top

// File: dv/tpo_timer_model.sv
// Stand-in for the timer channels and the DMA controller beside the block.
// Assumes the bench raises each fire command for exactly one cycle.
`timescale 1ns/1ns
module tpo_timer_model (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [2:0] i_fire_a,
    input wire logic [2:0] i_fire_b,
    input wire logic [2:0] i_dma_req,
    output logic [2:0] o_cmp_a,
    output logic [2:0] o_cmp_b,
    output logic [11:0] o_dma_cnt
);
    // Compare pulses leave a flop, as a real timer raises them off its edge
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_cmp_a <= 3'h0;
            o_cmp_b <= 3'h0;
        end else begin
            o_cmp_a <= i_fire_a;
            o_cmp_b <= i_fire_b;
        end
    end

    // DMA request count, four bits per channel
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_dma_cnt <= 12'h000;
        end else begin
            for (int c = 0; c < 3; c++) begin
                if (i_dma_req[c]) begin
                    o_dma_cnt[c*4 +: 4] <= o_dma_cnt[c*4 +: 4] + 4'h1;
                end
            end
        end
    end
endmodule // tpo_timer_model

// File: dv/timing_pattern_output_test.sv
// Self-checking bench of the timing pattern output block.
// Assumes an AHB-Lite master of single word transfers and a 50 MHz clock.
`timescale 1ns/1ns
module timing_pattern_output_test
    import tpo_pkg::*;
;
    typedef struct packed {
        logic wr;
        logic [19:0] idx;
        logic [7:0] wd;
        logic [7:0] want;
    } tpo_row_t;

    // Register rows: reset values first, then write and read back
    localparam tpo_row_t ROWS [19] = '{
        '{1'h0, IDX_MODE, 8'h00, 8'hF0}, '{1'h0, IDX_TRIG_SEL, 8'h00, 8'hFF},
        '{1'h0, IDX_HI_EN, 8'h00, 8'h00}, '{1'h0, IDX_LO_EN, 8'h00, 8'h00},
        '{1'h0, IDX_HI_STAGED, 8'h00, 8'h00}, '{1'h0, IDX_LO_STAGED, 8'h00, 8'h00},
        '{1'h0, IDX_PORTA_DATA, 8'h00, 8'h00}, '{1'h0, IDX_PORTB_DATA, 8'h00, 8'h00},
        '{1'h0, IDX_PORTA_DIR, 8'h00, 8'h00}, '{1'h0, IDX_PORTB_DIR, 8'h00, 8'h00},
        '{1'h0, IDX_LO_ALT, 8'h00, 8'hFF}, '{1'h0, IDX_HI_ALT, 8'h00, 8'hFF},
        '{1'h1, IDX_HI_ALT, 8'h00, 8'hFF}, '{1'h1, IDX_MODE, 8'h5A, 8'hFA},
        '{1'h1, IDX_MODE, 8'h00, 8'hF0}, '{1'h1, 20'h00123, 8'hA5, 8'h00},
        '{1'h1, IDX_PORTA_DIR, 8'hFF, 8'h00}, '{1'h1, IDX_PORTA_DATA, 8'h5A, 8'h5A},
        '{1'h1, IDX_TRIG_SEL, 8'h64, 8'h64}
    };

    logic core_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] fire_a = 3'h0;
    logic [2:0] fire_b = 3'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [2:0] cmp_a;
    logic [2:0] cmp_b;
    logic [15:0] pins;
    logic [15:0] dirs;
    logic [2:0] dma_req;
    logic [11:0] dma_cnt;
    logic [7:0] rd;
    int err_total = 0;
    int check_count = 0;

    // Free-running clock, 20 ns period
    always #10 core_clk = ~core_clk;

    tpo_top tpo_top_inst (
        .i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
        .o_hreadyout(hreadyout), .o_hresp(hresp), .i_cmp_a(cmp_a), .i_cmp_b(cmp_b),
        .o_pattern_pin(pins), .o_pattern_dir(dirs), .o_dma_req(dma_req)
    );

    tpo_timer_model tpo_timer_model_inst (
        .i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_fire_a(fire_a),
        .i_fire_b(fire_b), .i_dma_req(dma_req), .o_cmp_a(cmp_a),
        .o_cmp_b(cmp_b), .o_dma_cnt(dma_cnt)
    );

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, want, seen);
        end
    endtask

    // One single transfer; waits on hready only, read data taken at the last edge
    task automatic bus(input logic wr, input logic [19:0] idx, input logic [7:0] wd);
        @(posedge core_clk);
        hsel <= 1'h1;
        haddr <= {10'h000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        do @(posedge core_clk); while (hreadyout !== 1'h1);
        rd = hrdata[7:0];
        check("hresp", 16'(hresp), 16'h0000);
    endtask

    task automatic rw(input logic wr, input logic [19:0] idx, input logic [7:0] wd,
                      input logic [7:0] want, input string name);
        if (wr) begin
            bus(1'h1, idx, wd);
        end
        bus(1'h0, idx, 8'h00);
        check(name, 16'(rd), 16'(want));
    endtask

    // Fire compare events; latches and DMA must move two edges after the pulse
    task automatic pulse(input logic [2:0] a, input logic [2:0] b,
                         input logic [15:0] want_pin, input logic [2:0] want_dma);
        @(posedge core_clk);
        fire_a <= a;
        fire_b <= b;
        @(posedge core_clk);
        fire_a <= 3'h0;
        fire_b <= 3'h0;
        @(posedge core_clk);
        #1;
        check("dma_early", 16'(dma_req), 16'h0000);
        @(posedge core_clk);
        #1;
        check("pins", pins, want_pin);
        check("dma", 16'(dma_req), 16'(want_dma));
        @(posedge core_clk);
        #1;
        check("dma_end", 16'(dma_req), 16'h0000);
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence: table rows, then triggers, non-overlap, remap, reset
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'h0;
        for (int i = 0; i < 19; i++) begin
            rw(ROWS[i].wr, ROWS[i].idx, ROWS[i].wd, ROWS[i].want, "reg");
        end
        bus(1'h1, IDX_LO_EN, 8'hFF);
        bus(1'h1, IDX_HI_EN, 8'h0F);
        bus(1'h1, IDX_PORTB_DIR, 8'hFF);
        #1;
        check("dir", dirs, 16'hFFFF);
        rw(1'h1, IDX_LO_STAGED, 8'hA5, 8'hAF, "lo_stg");
        rw(1'h1, IDX_LO_ALT, 8'h3C, 8'hFC, "lo_alt");
        rw(1'h1, IDX_HI_STAGED, 8'h69, 8'h6F, "hi_stg");
        rw(1'h1, IDX_HI_ALT, 8'h12, 8'hF2, "hi_alt");
        rw(1'h1, IDX_PORTB_DATA, 8'hFF, 8'hF0, "b_data");
        rw(1'h1, IDX_PORTA_DATA, 8'h00, 8'h5A, "a_data");
        pulse(3'h1, 3'h0, 16'hF05C, 3'h1);
        pulse(3'h2, 3'h0, 16'hF0AC, 3'h2);
        pulse(3'h4, 3'h0, 16'hF2AC, 3'h4);
        // Non-overlap on groups 0 and 1: falling bits on A, rising bits on B
        bus(1'h1, IDX_MODE, 8'h03);
        bus(1'h1, IDX_LO_ALT, 8'h03);
        pulse(3'h1, 3'h0, 16'hF2A0, 3'h1);
        pulse(3'h0, 3'h1, 16'hF2A3, 3'h0);
        bus(1'h1, IDX_LO_STAGED, 8'h58);
        pulse(3'h2, 3'h0, 16'hF203, 3'h2);
        pulse(3'h0, 3'h2, 16'hF253, 3'h0);
        check("dma_cnt", 16'(dma_cnt), 16'h0122);
        // Codes 2 and 3 name one channel, so the low halves fold as well
        bus(1'h1, IDX_TRIG_SEL, 8'h0B);
        rw(1'h0, IDX_LO_STAGED, 8'h00, 8'h53, "lo_same");
        rw(1'h0, IDX_LO_ALT, 8'h00, 8'hFF, "lo_rsv");
        rw(1'h0, IDX_HI_STAGED, 8'h00, 8'h62, "hi_same");
        rw(1'h0, IDX_HI_ALT, 8'h00, 8'hFF, "hi_rsv");
        // Groups 2 and 3 on the first channel with every bit enabled
        bus(1'h1, IDX_HI_EN, 8'hFF);
        pulse(3'h1, 3'h0, 16'h6253, 3'h1);
        // Reset again in mid-run, outputs must clear and registers return to reset values
        @(posedge core_clk);
        sys_rst <= 1'h1;
        repeat (2) @(posedge core_clk);
        #1;
        check("pins_rst", pins, 16'h0000);
        check("dir_rst", dirs, 16'h0000);
        @(posedge core_clk);
        sys_rst <= 1'h0;
        rw(1'h0, IDX_TRIG_SEL, 8'h00, 8'hFF, "trig_rst");
        give_verdict();
    end

    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        give_verdict();
    end
endmodule // timing_pattern_output_test
